// ---- src/dac_serial_pkg.sv ----
// Package holding constants and carrier types of the serial DAC control block.
package dac_serial_pkg;
	// ----------------------------------------------------------------------
	// Word layout
	// ----------------------------------------------------------------------
	localparam int WORD_BITS     = 16;
	localparam int DATA_BITS_MAX = 14;
	localparam int CNT_BITS      = 5;
	localparam logic [4:0] WORD_COUNT = 5'h10;
	localparam logic [4:0] CNT_ZERO   = 5'h00;
	localparam logic [4:0] CNT_ONE    = 5'h01;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [13:0] DATA_ZERO = 14'h0000;

	// ----------------------------------------------------------------------
	// Synchroniser and FIFO
	// ----------------------------------------------------------------------
	localparam int SYNC_STAGES = 3;
	localparam int FIFO_DEPTH  = 16;

	// Sampled pin levels, after synchronisation.
	typedef struct packed {
		logic sclk;
		logic serial_in;
		logic frame_n;
		logic load_strobe_n;
		logic readback_enable_n;
		logic output_clear_n;
		logic power_down_n;
	} pins_t;

	localparam int PINS_BITS = 7;
	localparam logic [6:0] PINS_IDLE = 7'h7F;

	// Frame states.
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SHIFT  = 2'b01,
		ST_ARMED  = 2'b10
	} frame_state_t;
endpackage

// ---- src/serial_dac_load_readback.sv ----
// Serial load, deferred update, readback and pass-through logic of a serial DAC.
`timescale 1ns/1ns

// --------------------------------------------------------------------------
// Word FIFO between the serial receiver and the DAC register.
// --------------------------------------------------------------------------
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	// Honest full and empty from an occupancy count.
	assign in_ready  = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ;
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_r[rp_r];

	// Pointer and count arithmetic.
	always_comb begin
		wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
		rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
		cnt_nxt = (AW+1)'(cnt_r + (AW+1)'(push) - (AW+1)'(pop));
	end

	// Storage has no reset; only the pointers and the count carry control state.
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
		if (!rst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// --------------------------------------------------------------------------
// Top level.
// --------------------------------------------------------------------------
// Behaviour
// R1 - Each frame carries exactly one 16-bit word into the input shift register.
// R2 - Only 12 or 14 bits of the word are DAC data; the rest ignored.
// R3 - After frame falls, one input bit shifts in per falling serial clock edge.
// R4 - Load strobe level sampled at frame fall picks synchronous or deferred update.
// R5 - Strobe low at frame fall: DAC register loads at frame rise.
// R6 - Strobe high at frame fall: load waits for strobe low after the word.
// R7 - Host may tie load strobe low so every frame updates automatically.
// R8 - Without readback, input bits reappear at the serial output 16 clocks later.
// R9 - Serial output changes on the falling serial clock edge.
// R10 - Power-down leaves the DAC register untouched.
// R11 - Readback enable low copies DAC register into shift register next fall.
// R12 - Host frames readback by 16 clocks low or raising enable after hold.
// R13 - During readback the captured word shifts out one bit per falling edge.
// R14 - The two top bits of the readback word are zeros.
// R15 - Clear falling edge grounds output; input and DAC registers keep contents.
// R16 - After clear rises, output restores at next strobe, or at once if tied low.
// R17 - DAC data field is straight unsigned binary.
// R18 - Host holds every data bit stable at the falling serial clock edge.
// R19 - Host sends the word most significant bit first.
// R20 - Serial output is open drain, pulling low only.
// R21 - DAC data occupies the low bits of the word; upper bits don't care.
module serial_dac_load_readback #(
	parameter int DATA_BITS  = dac_serial_pkg::DATA_BITS_MAX,
	parameter int FIFO_DEPTH = dac_serial_pkg::FIFO_DEPTH
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire logic                 sclk,
	input  wire logic                 serial_in,
	input  wire logic                 frame_n,
	input  wire logic                 load_strobe_n,
	input  wire logic                 readback_enable_n,
	input  wire logic                 output_clear_n,
	input  wire logic                 power_down_n,
	output logic                      serial_out_o,
	output logic                      serial_out_oe,
	output logic      [DATA_BITS-1:0] dac_code,
	output logic                      output_grounded,
	output logic                      powered_down,
	output logic                      word_overflow
);
	localparam int PB = dac_serial_pkg::PINS_BITS;

	// ----------------------------------------------------------------------
	// Pin synchronisers: a change counts once stages two and three agree.
	// ----------------------------------------------------------------------
	logic [PB-1:0] s1_r, s2_r, s3_r, st_r;
	logic [PB-1:0] s1_nxt, s2_nxt, s3_nxt, st_nxt;
	dac_serial_pkg::pins_t pin_now, pin_prev;

	// A level only moves once two later stages agree, filtering single glitches.
	always_comb begin
		s1_nxt = {sclk, serial_in, frame_n, load_strobe_n, readback_enable_n,
			output_clear_n, power_down_n};
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		st_nxt = st_r;
		for (int i = 0; i < PB; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				st_nxt[i] = s3_r[i];
			end
		end
	end

	// Synchroniser stages and the accepted levels.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s1_r <= dac_serial_pkg::PINS_IDLE;
			s2_r <= dac_serial_pkg::PINS_IDLE;
			s3_r <= dac_serial_pkg::PINS_IDLE;
			st_r <= dac_serial_pkg::PINS_IDLE;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			st_r <= st_nxt;
		end
	end

	// Stable level is the current view; its previous value gives edges.
	logic [PB-1:0] stp_r;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			stp_r <= dac_serial_pkg::PINS_IDLE;
		end else begin
			stp_r <= st_r;
		end
	end
	assign pin_now  = dac_serial_pkg::pins_t'(st_r);
	assign pin_prev = dac_serial_pkg::pins_t'(stp_r);

	logic sclk_fall, frame_fall, frame_rise, strobe_fall, rb_fall, clr_fall, clr_rise;
	assign sclk_fall   = pin_prev.sclk && !pin_now.sclk;
	assign frame_fall  = pin_prev.frame_n && !pin_now.frame_n;
	assign frame_rise  = !pin_prev.frame_n && pin_now.frame_n;
	assign strobe_fall = pin_prev.load_strobe_n && !pin_now.load_strobe_n;
	assign rb_fall     = pin_prev.readback_enable_n && !pin_now.readback_enable_n;
	assign clr_fall    = pin_prev.output_clear_n && !pin_now.output_clear_n;
	assign clr_rise    = !pin_prev.output_clear_n && pin_now.output_clear_n;

	// ----------------------------------------------------------------------
	// Frame receiver and shift register.
	// ----------------------------------------------------------------------
	dac_serial_pkg::frame_state_t state_r, state_nxt;
	logic [dac_serial_pkg::WORD_BITS-1:0] shift_r, shift_nxt;
	logic [dac_serial_pkg::CNT_BITS-1:0]  cnt_r, cnt_nxt;
	logic deferred_r, deferred_nxt;
	logic rb_pending_r, rb_pending_nxt;
	logic out_bit_r, out_bit_nxt;
	logic push;
	logic fifo_ready;
	logic [dac_serial_pkg::WORD_BITS-1:0] word_pushed;
	logic [DATA_BITS-1:0] dac_r, dac_nxt;

	// The word goes to the FIFO at frame rise; deferred words wait for the strobe.
	always_comb begin
		state_nxt      = state_r;
		shift_nxt      = shift_r;
		cnt_nxt        = cnt_r;
		deferred_nxt   = deferred_r;
		rb_pending_nxt = rb_pending_r;
		out_bit_nxt    = out_bit_r;
		push           = 1'b0;
		word_pushed    = shift_r;
		if (rb_fall) begin
			rb_pending_nxt = 1'b1;
		end
		unique case (state_r)
			dac_serial_pkg::ST_IDLE: begin
				if (frame_fall) begin
					deferred_nxt = pin_now.load_strobe_n; // R4
					cnt_nxt      = dac_serial_pkg::CNT_ZERO;
					state_nxt    = dac_serial_pkg::ST_SHIFT;
				end
			end
			dac_serial_pkg::ST_SHIFT: begin
				if (frame_rise) begin
					// Only a full word counts; short or long frames are dropped.
					if (cnt_r == dac_serial_pkg::WORD_COUNT) begin // R1
						if (deferred_r) begin
							state_nxt = dac_serial_pkg::ST_ARMED; // R6
						end else begin
							push      = 1'b1; // R5
							state_nxt = dac_serial_pkg::ST_IDLE;
						end
					end else begin
						state_nxt = dac_serial_pkg::ST_IDLE;
					end
				end
			end
			dac_serial_pkg::ST_ARMED: begin
				if (!pin_now.load_strobe_n) begin
					push      = 1'b1; // R6
					state_nxt = dac_serial_pkg::ST_IDLE;
				end else if (frame_fall) begin
					// A newer frame replaces the word still waiting for the strobe.
					deferred_nxt = pin_now.load_strobe_n; // R4
					cnt_nxt      = dac_serial_pkg::CNT_ZERO;
					state_nxt    = dac_serial_pkg::ST_SHIFT;
				end
			end
		endcase
		if (sclk_fall) begin
			out_bit_nxt = shift_r[dac_serial_pkg::WORD_BITS-1]; // R9 R8
			if (rb_pending_r || (rb_fall)) begin
				// Readback: the zero-extended DAC word replaces the shift register.
				// Its top bit leaves on this same fall, so the register keeps the word
				// already moved up by one. Otherwise the top bit would go out twice.
				shift_nxt      = dac_serial_pkg::WORD_BITS'({dac_r, pin_now.serial_in}); // R11 R14
				out_bit_nxt    = 1'b0; // R14
				rb_pending_nxt = 1'b0;
			end else begin
				// MSB first: the bit leaving the top is the output bit.
				shift_nxt = {shift_r[dac_serial_pkg::WORD_BITS-2:0],
					pin_now.serial_in}; // R3 R8 R13
			end
			if (state_r == dac_serial_pkg::ST_SHIFT && !pin_now.frame_n &&
				cnt_r != dac_serial_pkg::WORD_COUNT + dac_serial_pkg::CNT_ONE) begin
				cnt_nxt = dac_serial_pkg::CNT_BITS'(cnt_r + dac_serial_pkg::CNT_ONE);
			end
		end
	end

	// Frame state, shift register and output bit.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r      <= dac_serial_pkg::ST_IDLE;
			shift_r      <= dac_serial_pkg::WORD_ZERO;
			cnt_r        <= dac_serial_pkg::CNT_ZERO;
			deferred_r   <= 1'b0;
			rb_pending_r <= 1'b0;
			out_bit_r    <= 1'b1;
		end else begin
			state_r      <= state_nxt;
			shift_r      <= shift_nxt;
			cnt_r        <= cnt_nxt;
			deferred_r   <= deferred_nxt;
			rb_pending_r <= rb_pending_nxt;
			out_bit_r    <= out_bit_nxt;
		end
	end

	// ----------------------------------------------------------------------
	// Word FIFO feeding the DAC register.
	// ----------------------------------------------------------------------
	logic                                 f_valid;
	logic [dac_serial_pkg::WORD_BITS-1:0] f_data;

	word_fifo #(
		.WIDTH (dac_serial_pkg::WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (word_pushed),
		.out_valid (f_valid),
		.out_ready (1'b1),
		.out_data  (f_data)
	);

	// ----------------------------------------------------------------------
	// DAC register, clear and power-down state.
	// ----------------------------------------------------------------------
	logic clear_r, clear_nxt, ovf_r, ovf_nxt;

	// Clear only grounds the output; registers keep their data throughout.
	always_comb begin
		dac_nxt   = dac_r;
		clear_nxt = clear_r;
		ovf_nxt   = ovf_r || (push && !fifo_ready);
		if (f_valid) begin
			dac_nxt = f_data[DATA_BITS-1:0]; // R2 R21 R17
		end
		if (clr_fall) begin
			clear_nxt = 1'b1; // R15
		end else if (clear_r && pin_now.output_clear_n &&
			(!pin_now.load_strobe_n || strobe_fall)) begin
			clear_nxt = 1'b0; // R16
		end
	end

	// DAC register, clear and overflow flags.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dac_r   <= DATA_BITS'(dac_serial_pkg::DATA_ZERO);
			clear_r <= 1'b0;
			ovf_r   <= 1'b0;
		end else begin
			dac_r   <= dac_nxt; // R10
			clear_r <= clear_nxt;
			ovf_r   <= ovf_nxt;
		end
	end

	// Open drain: drive only a low level, release for a high.
	assign serial_out_o    = 1'b0; // R20
	assign serial_out_oe   = !out_bit_r; // R20
	assign dac_code        = clear_r ? DATA_BITS'(dac_serial_pkg::DATA_ZERO) : dac_r;
	assign output_grounded = clear_r;
	assign powered_down    = !pin_now.power_down_n; // R10
	assign word_overflow   = ovf_r;
endmodule

// ---- testbench/dac_host_model.sv ----
// Host serial master model: frames words, clocks bits and samples the open-drain line.
`timescale 1ns/1ns
module dac_host_model (
	input  wire logic        sys_clk,
	input  wire logic        line_level,
	output logic             sclk,
	output logic             serial_in,
	output logic             frame_n,
	output logic             rx_done,
	output logic      [15:0] rx
);
	// Idle link: clock parked high, frame released.
	initial begin
		sclk = 1'b1;
		serial_in = 1'b0;
		frame_n = 1'b1;
		rx_done = 1'b0;
		rx = 16'h0000;
	end

	// Clock n bits out MSB first; the line is taken before each later fall and once after
	// the last, so the low n bits of rx are the bits the device put out during this transfer.
	task automatic xfer(input logic [15:0] d, input int n, input logic framed);
		frame_n <= !framed;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < n; i++) begin
			serial_in <= d[15-i];
			sclk <= 1'b1;
			repeat (4) @(posedge sys_clk);
			if (i > 0)
				rx <= {rx[14:0], line_level};
			sclk <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
		sclk <= 1'b1;
		serial_in <= !serial_in;
		repeat (4) @(posedge sys_clk);
		rx <= {rx[14:0], line_level};
		frame_n <= 1'b1;
		rx_done <= 1'b1;
		@(posedge sys_clk);
		rx_done <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule

// ---- testbench/dac_serial_props.sv ----
// Concurrent checks on the ports of the serial DAC control block.
`timescale 1ns/1ns
module dac_serial_props #(
	parameter int DATA_BITS = 14
) (
	input wire logic                 sys_clk,
	input wire logic                 rst_n,
	input wire logic                 sclk,
	input wire logic                 frame_n,
	input wire logic                 load_strobe_n,
	input wire logic                 readback_enable_n,
	input wire logic                 output_clear_n,
	input wire logic                 serial_out_o,
	input wire logic                 serial_out_oe,
	input wire logic [DATA_BITS-1:0] dac_code,
	input wire logic                 output_grounded,
	input wire logic                 powered_down,
	input wire logic                 word_overflow
);
	// ------------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------------
	logic [3:0] quiet_r;
	logic [3:0] quiet_nxt;
	logic [3:0] sclk_hi_r;
	logic [3:0] sclk_hi_nxt;

	// Saturating counts of idle control pins and of a high link clock; the
	// saturation keeps a long idle spell from wrapping back into the window.
	always_comb begin
		quiet_nxt = 4'h0;
		sclk_hi_nxt = 4'h0;
		if (rst_n && frame_n && load_strobe_n && output_clear_n)
			quiet_nxt = quiet_r + {3'h0, quiet_r != 4'hF};
		if (rst_n && sclk)
			sclk_hi_nxt = sclk_hi_r + {3'h0, sclk_hi_r != 4'hF};
	end

	// Registers of the helper counters.
	always_ff @(posedge sys_clk) begin
		quiet_r <= quiet_nxt;
		sclk_hi_r <= sclk_hi_nxt;
	end

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_open_drain; serial_out_o == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("serial line driven high");
	property p_sclk_idle; sclk_hi_r > 4'h6 |-> $stable(serial_out_oe); endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("serial out moved off a fall");
	property p_quiet; quiet_r > 4'hA |-> $stable(dac_code); endproperty
	a_quiet: assert property (p_quiet) else $error("DAC word loaded without strobe");
	property p_ground_zero; output_grounded && $past(output_grounded) |-> dac_code == '0; endproperty
	a_ground_zero: assert property (p_ground_zero) else $error("grounded output not zero");
	property p_clear_grounds; $fell(output_clear_n) |-> ##[1:8] output_grounded; endproperty
	a_clear_grounds: assert property (p_clear_grounds) else $error("clear ignored");
	property p_auto_restore;
		$rose(output_clear_n) && !load_strobe_n |-> ##[1:10] !output_grounded;
	endproperty
	a_auto_restore: assert property (p_auto_restore) else $error("no automatic restore");
	property p_pd_keeps; $changed(powered_down) |-> $stable(dac_code); endproperty
	a_pd_keeps: assert property (p_pd_keeps) else $error("power-down altered DAC word");
	property p_no_overflow; !word_overflow; endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("word lost in FIFO");

	c_sync_load: cover property ($rose(frame_n) && !load_strobe_n);
	c_deferred: cover property ($fell(load_strobe_n) && frame_n);
	c_readback: cover property ($fell(readback_enable_n));
endmodule

bind serial_dac_load_readback dac_serial_props #(.DATA_BITS(DATA_BITS)) props_u (.sys_clk,
	.rst_n, .sclk, .frame_n, .load_strobe_n, .readback_enable_n, .output_clear_n, .serial_out_o,
	.serial_out_oe, .dac_code, .output_grounded, .powered_down, .word_overflow);

// ---- testbench/testbench.sv ----
// Self-checking bench of the serial DAC control block.
`timescale 1ns/1ns
module testbench;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        load_strobe_n = 1'b0;
	logic        readback_enable_n = 1'b1;
	logic        output_clear_n = 1'b1;
	logic        power_down_n = 1'b1;
	logic        rx_chk = 1'b0;
	logic        snap_r = 1'b0;
	logic        sclk, serial_in, frame_n, rx_done, line;
	logic        serial_out_o, serial_out_oe, output_grounded, powered_down;
	logic [13:0] dac_code, dac_w;
	logic [15:0] rx, w, e, got;
	logic [31:0] seed = 32'h9223;
	logic [15:0] q[$];
	int          mismatches = 0;
	int          checks = 0;
	int          cycles = 0;

	always #25 sys_clk = ~sys_clk;
	// Pull-up on the open-drain serial line.
	assign line = serial_out_oe ? serial_out_o : 1'b1;

	serial_dac_load_readback dut_u (.sys_clk, .rst_n, .sclk, .serial_in, .frame_n, .load_strobe_n,
		.readback_enable_n, .output_clear_n, .power_down_n, .serial_out_o, .serial_out_oe,
		.dac_code, .output_grounded, .powered_down, .word_overflow());
	dac_host_model host_u (.sys_clk, .line_level(line), .sclk, .serial_in, .frame_n, .rx_done, .rx);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic test_done();
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Note the expected status word; the monitor takes it at the next edge.
	task automatic snap(input logic [15:0] exp);
		q.push_back(exp);
		snap_r <= 1'b1;
		@(posedge sys_clk);
		snap_r <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic send(input logic [15:0] d, input int n, input logic framed, input logic chk,
		input logic [15:0] exp);
		rx_chk = chk;
		if (chk)
			q.push_back(exp);
		host_u.xfer(d, n, framed);
	endtask

	// Take the oldest expectation whenever a snapshot or a checked received word shows up.
	always @(posedge sys_clk) begin
		if (snap_r || (rx_done && rx_chk)) begin
			e = q.pop_front();
			got = snap_r ? {output_grounded, powered_down, dac_code} : rx;
			checks++;
			if (got !== e) begin
				mismatches++;
				$display("CHECK FAILED at %0t: expected %h, got %h", $time, e, got);
			end
		end
	end

	// Hang guard, well above the roughly 1200 cycles the sequence needs.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			mismatches++;
			test_done();
		end
	end

	// Main sequence; the strobe stays low unless a step lifts it.
	initial begin
		wait_clk(16);
		rst_n <= 1'b1;
		wait_clk(8);
		snap(16'h0000);
		w = 16'h0000;
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			send(seed[15:0], 16, 1'b1, k > 0, w);
			w = seed[15:0];
			dac_w = w[13:0];
			wait_clk(12);
			snap({2'b00, dac_w});
		end
		send(16'hFFFF, 15, 1'b1, 1'b0, w);
		wait_clk(12);
		snap({2'b00, dac_w});
		// Deferred update: strobe high well before the frame falls.
		load_strobe_n <= 1'b1;
		wait_clk(4);
		seed = lfsr(seed);
		send(seed[15:0], 16, 1'b1, 1'b0, w);
		wait_clk(12);
		snap({2'b00, dac_w});
		load_strobe_n <= 1'b0;
		dac_w = seed[13:0];
		wait_clk(12);
		snap({2'b00, dac_w});
		// Readback with the enable held low for a whole word.
		readback_enable_n <= 1'b0;
		send(~seed[15:0], 16, 1'b0, 1'b1, {2'b00, dac_w});
		readback_enable_n <= 1'b1;
		power_down_n <= 1'b0;
		wait_clk(12);
		snap({2'b01, dac_w});
		power_down_n <= 1'b1;
		wait_clk(12);
		snap({2'b00, dac_w});
		// Clear, restored first by a strobe fall, then by a strobe held low.
		load_strobe_n <= 1'b1;
		output_clear_n <= 1'b0;
		wait_clk(12);
		snap(16'h8000);
		output_clear_n <= 1'b1;
		wait_clk(12);
		snap(16'h8000);
		load_strobe_n <= 1'b0;
		wait_clk(12);
		snap({2'b00, dac_w});
		output_clear_n <= 1'b0;
		wait_clk(12);
		output_clear_n <= 1'b1;
		wait_clk(12);
		snap({2'b00, dac_w});
		test_done();
	end
endmodule
